// ### logic/mpc_pkg.sv
// constants and state codes for the motor pwm pin control block
// Summary of operation
// [R1] reset pin low: restart, pwm pins high-z
// [R2] drive reset pin low on internal reset
// [R3] sample polarity and base frequency at init
// [R4] six pwm outputs, top and bottom per phase
// [R5] fault high disables pwm outputs at once
// [R6] retry interval runs only after fault low
// [R7] standalone: rate strobe low during conversion
// [R8] host mode: shared pin receives uart data
// [R9] standalone dead time clamped 0.5 to 6.0 us
// [R10] standalone retry wait clamped to ~53 s
// [R11] mode strap high standalone, low host
// [R12] outputs held off for retry wait, then on
// [R13] never both sides on; dead time inserted
`default_nettype none
package mpc_pkg;
   localparam int CLK_MHZ = 200;
   localparam int INIT_SETTLE_NS = 1000;
   localparam int INIT_SETTLE_CYC = (INIT_SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_W = 8;
   localparam int DT_CODE_W = 8;
   localparam int DT_CNT_W = 13;
   localparam int DT_UNIT_NS = 125;
   localparam int DT_UNIT_CYC = DT_UNIT_NS * CLK_MHZ / 1000;
   localparam int DT_SA_MIN_NS = 500;
   localparam int DT_SA_MAX_NS = 6000;
   localparam logic [DT_CODE_W-1:0] DT_SA_MIN_CODE = DT_CODE_W'(DT_SA_MIN_NS / DT_UNIT_NS);
   localparam logic [DT_CODE_W-1:0] DT_SA_MAX_CODE = DT_CODE_W'(DT_SA_MAX_NS / DT_UNIT_NS);
   localparam int RETRY_W = 16;
   localparam int RETRY_UNIT_MS = 250;
   localparam int RETRY_SA_MAX_S = 53;
   localparam logic [RETRY_W-1:0] RETRY_SA_MAX_CODE =
      RETRY_W'(RETRY_SA_MAX_S * 1000 / RETRY_UNIT_MS);
   localparam int TICK_W = 26;
   localparam int RETRY_UNIT_CYC = RETRY_UNIT_MS * CLK_MHZ * 1000;
   localparam int PHASES = 3;
   localparam int PH_U = 0;
   localparam int PH_V = 1;
   localparam int PH_W = 2;

   typedef enum logic [5:0] {
      ST_STRAP = 6'h01,
      ST_POL = 6'h02,
      ST_FREQ = 6'h04,
      ST_RUN = 6'h08,
      ST_FAULT = 6'h10,
      ST_RETRY = 6'h20
   } mpc_state_type;
endpackage
`default_nettype wire

// ### logic/mpc_phase_if.sv
// bundle between the pwm controller and its per-phase gate stages
`timescale 1ns/100ps
`default_nettype none
interface mpc_phase_if;
   logic enable;
   logic [mpc_pkg::DT_CNT_W-1:0] dead_cycles;
   logic [mpc_pkg::PHASES-1:0] demand;
   wire [mpc_pkg::PHASES-1:0] top_on;
   wire [mpc_pkg::PHASES-1:0] bot_on;
   modport ctrl (output enable, output dead_cycles, output demand, input top_on, input bot_on);
   modport gate (input enable, input dead_cycles, input demand, output top_on, output bot_on);
endinterface
`default_nettype wire

// ### logic/mpc_phase_gate.sv
// one phase: complementary drive with dead time between sides
`timescale 1ns/100ps
`default_nettype none
module mpc_phase_gate #(
   parameter int PHASE = 0
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   mpc_phase_if.gate bus
);
   logic side;
   logic top;
   logic bot;
   logic [mpc_pkg::DT_CNT_W-1:0] cnt;

   // [R13] break before make
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         side <= 1'b0;
         top <= 1'b0;
         bot <= 1'b0;
         cnt <= '0;
      end else if (!bus.enable || bus.demand[PHASE] != side) begin
         side <= bus.demand[PHASE];
         top <= 1'b0;
         bot <= 1'b0;
         cnt <= bus.dead_cycles;
      end else if (cnt != '0) begin
         cnt <= cnt - 1'b1;
      end else begin
         top <= side;
         bot <= ~side;
      end
   end

   assign bus.top_on[PHASE] = top;
   assign bus.bot_on[PHASE] = bot;
endmodule
`default_nettype wire

// ### logic/mpc_top.sv
// pin-level pwm output, fault, retry and init strap control
`timescale 1ns/100ps
`default_nettype none
module mpc_top #(
   parameter int RETRY_TICK_CYCLES = mpc_pkg::RETRY_UNIT_CYC
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic reset_pin_i,
   output logic reset_pin_o,
   output logic reset_pin_oe_o,
   input wire logic clock_loss_i,
   input wire logic low_supply_i,
   input wire logic polarity_base_freq_select_i,
   input wire logic mode_strap_boost_strobe_i,
   output logic mode_strap_boost_strobe_o,
   output logic mode_strap_boost_strobe_oe_o,
   input wire logic boost_conversion_active_i,
   input wire logic system_fault_input_i,
   input wire logic pwm_rate_strobe_or_serial_rx_i,
   output logic pwm_rate_strobe_or_serial_rx_o,
   output logic pwm_rate_strobe_or_serial_rx_oe_o,
   input wire logic rate_conversion_active_i,
   output logic serial_rx_data_o,
   input wire logic [mpc_pkg::PHASES-1:0] phase_demand_i,
   input wire logic [mpc_pkg::DT_CODE_W-1:0] dead_time_code_i,
   input wire logic [mpc_pkg::RETRY_W-1:0] retry_time_code_i,
   output logic phase_u_high_side_out_o,
   output logic phase_u_high_side_out_oe_o,
   output logic phase_u_low_side_out_o,
   output logic phase_u_low_side_out_oe_o,
   output logic phase_v_high_side_out_o,
   output logic phase_v_high_side_out_oe_o,
   output logic phase_v_low_side_out_o,
   output logic phase_v_low_side_out_oe_o,
   output logic phase_w_high_side_out_o,
   output logic phase_w_high_side_out_oe_o,
   output logic phase_w_low_side_out_o,
   output logic phase_w_low_side_out_oe_o,
   output logic standalone_mode_o,
   output logic pwm_active_low_o,
   output logic base_freq_60_o,
   output logic fault_active_o,
   output logic pwm_running_o
);
   mpc_pkg::mpc_state_type state;
   mpc_pkg::mpc_state_type next_state;
   logic pin_reset;
   logic standalone;
   logic active_low;
   logic freq_60;
   logic [mpc_pkg::SETTLE_W-1:0] settle_cnt;
   logic settle_done;
   logic [mpc_pkg::DT_CODE_W-1:0] dt_code;
   logic [mpc_pkg::DT_CNT_W-1:0] dead_cycles;
   logic [mpc_pkg::RETRY_W-1:0] retry_code;
   logic [mpc_pkg::RETRY_W-1:0] retry_left;
   logic [mpc_pkg::TICK_W-1:0] tick_cnt;
   logic tick;
   logic [mpc_pkg::PHASES-1:0] hi_pin;
   logic [mpc_pkg::PHASES-1:0] lo_pin;
   logic pwm_oe;

   mpc_phase_if phase_bus ();

   // [R1] reset pin low acts as synchronous restart
   assign pin_reset = ~reset_pin_i;
   assign settle_done = (settle_cnt == mpc_pkg::SETTLE_W'(mpc_pkg::INIT_SETTLE_CYC - 1));
   assign tick = (tick_cnt == mpc_pkg::TICK_W'(RETRY_TICK_CYCLES - 1));

   // [R2] open-drain pull on internal reset sources
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reset_pin_o <= 1'b0;
         reset_pin_oe_o <= 1'b0;
      end else begin
         reset_pin_o <= 1'b0;
         reset_pin_oe_o <= clock_loss_i | low_supply_i;
      end
   end

   // init settle timer between strap samples
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         settle_cnt <= '0;
      end else if (pin_reset || settle_done || !(state inside {mpc_pkg::ST_STRAP,
            mpc_pkg::ST_POL, mpc_pkg::ST_FREQ})) begin
         settle_cnt <= '0;
      end else begin
         settle_cnt <= settle_cnt + 1'b1;
      end
   end

   // [R11] mode strap sample
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         standalone <= 1'b0;
      end else if (pin_reset) begin
         standalone <= 1'b0;
      end else if (state == mpc_pkg::ST_STRAP && settle_done) begin
         standalone <= mode_strap_boost_strobe_i;
      end
   end

   // [R3] polarity then base frequency sample
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         active_low <= 1'b0;
         freq_60 <= 1'b0;
      end else if (pin_reset) begin
         active_low <= 1'b0;
         freq_60 <= 1'b0;
      end else if (settle_done && state == mpc_pkg::ST_POL) begin
         active_low <= polarity_base_freq_select_i;
      end else if (settle_done && state == mpc_pkg::ST_FREQ) begin
         freq_60 <= polarity_base_freq_select_i;
      end
   end

   // [R9] dead time clamp in standalone mode
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dt_code <= mpc_pkg::DT_SA_MIN_CODE;
      end else if (standalone && dead_time_code_i < mpc_pkg::DT_SA_MIN_CODE) begin
         dt_code <= mpc_pkg::DT_SA_MIN_CODE;
      end else if (standalone && dead_time_code_i > mpc_pkg::DT_SA_MAX_CODE) begin
         dt_code <= mpc_pkg::DT_SA_MAX_CODE;
      end else begin
         dt_code <= dead_time_code_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dead_cycles <= '0;
      end else begin
         dead_cycles <= mpc_pkg::DT_CNT_W'(dt_code) *
            mpc_pkg::DT_CNT_W'(mpc_pkg::DT_UNIT_CYC);
      end
   end

   // [R10] retry wait clamp in standalone mode
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         retry_code <= '0;
      end else if (standalone && retry_time_code_i > mpc_pkg::RETRY_SA_MAX_CODE) begin
         retry_code <= mpc_pkg::RETRY_SA_MAX_CODE;
      end else begin
         retry_code <= retry_time_code_i;
      end
   end

   always_comb begin
      next_state = state;
      unique case (state)
         mpc_pkg::ST_STRAP: begin
            if (settle_done) next_state = mpc_pkg::ST_POL;
         end
         mpc_pkg::ST_POL: begin
            if (settle_done) next_state = mpc_pkg::ST_FREQ;
         end
         mpc_pkg::ST_FREQ: begin
            if (settle_done) next_state = mpc_pkg::ST_RUN;
         end
         mpc_pkg::ST_RUN: begin
            if (system_fault_input_i) next_state = mpc_pkg::ST_FAULT;
         end
         mpc_pkg::ST_FAULT: begin
            // [R6] wait for fault release
            if (!system_fault_input_i) next_state = mpc_pkg::ST_RETRY;
         end
         mpc_pkg::ST_RETRY: begin
            if (system_fault_input_i) begin
               next_state = mpc_pkg::ST_FAULT;
            end else if (retry_left == '0) begin
               next_state = mpc_pkg::ST_RUN;
            end
         end
         default: next_state = mpc_pkg::ST_STRAP;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= mpc_pkg::ST_STRAP;
      end else if (pin_reset) begin
         state <= mpc_pkg::ST_STRAP;
      end else begin
         state <= next_state;
      end
   end

   // [R12] retry wait countdown in units
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         retry_left <= '0;
         tick_cnt <= '0;
      end else if (state != mpc_pkg::ST_RETRY || system_fault_input_i) begin
         retry_left <= retry_code;
         tick_cnt <= '0;
      end else if (tick) begin
         tick_cnt <= '0;
         if (retry_left != '0) retry_left <= retry_left - 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
      end
   end

   assign phase_bus.enable = (state == mpc_pkg::ST_RUN) && !system_fault_input_i;
   assign phase_bus.dead_cycles = dead_cycles;
   assign phase_bus.demand = phase_demand_i;

   // [R4] one gate stage per phase
   for (genvar p = 0; p < mpc_pkg::PHASES; p++) begin : g_phase
      mpc_phase_gate #(
         .PHASE(p)
      ) u_gate (
         .sys_clk_i(sys_clk_i),
         .reset_n_i(reset_n_i),
         .bus(phase_bus)
      );
   end

   // [R5] fault forces inactive level next edge
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hi_pin <= '0;
         lo_pin <= '0;
      end else if (pin_reset || system_fault_input_i || state != mpc_pkg::ST_RUN) begin
         hi_pin <= {mpc_pkg::PHASES{active_low}};
         lo_pin <= {mpc_pkg::PHASES{active_low}};
      end else begin
         hi_pin <= phase_bus.top_on ^ {mpc_pkg::PHASES{active_low}};
         lo_pin <= phase_bus.bot_on ^ {mpc_pkg::PHASES{active_low}};
      end
   end

   // [R1] pwm pins high-z until init done
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pwm_oe <= 1'b0;
      end else if (pin_reset) begin
         pwm_oe <= 1'b0;
      end else begin
         pwm_oe <= !(state inside {mpc_pkg::ST_STRAP, mpc_pkg::ST_POL, mpc_pkg::ST_FREQ});
      end
   end

   assign phase_u_high_side_out_o = hi_pin[mpc_pkg::PH_U];
   assign phase_u_low_side_out_o = lo_pin[mpc_pkg::PH_U];
   assign phase_v_high_side_out_o = hi_pin[mpc_pkg::PH_V];
   assign phase_v_low_side_out_o = lo_pin[mpc_pkg::PH_V];
   assign phase_w_high_side_out_o = hi_pin[mpc_pkg::PH_W];
   assign phase_w_low_side_out_o = lo_pin[mpc_pkg::PH_W];
   assign phase_u_high_side_out_oe_o = pwm_oe;
   assign phase_u_low_side_out_oe_o = pwm_oe;
   assign phase_v_high_side_out_oe_o = pwm_oe;
   assign phase_v_low_side_out_oe_o = pwm_oe;
   assign phase_w_high_side_out_oe_o = pwm_oe;
   assign phase_w_low_side_out_oe_o = pwm_oe;

   // shared pin direction by mode
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pwm_rate_strobe_or_serial_rx_o <= 1'b1;
         pwm_rate_strobe_or_serial_rx_oe_o <= 1'b0;
         serial_rx_data_o <= 1'b1;
      end else if (pin_reset || !pwm_oe) begin
         pwm_rate_strobe_or_serial_rx_o <= 1'b1;
         pwm_rate_strobe_or_serial_rx_oe_o <= 1'b0;
         serial_rx_data_o <= 1'b1;
      end else if (standalone) begin
         // [R7] low while rate input converts
         pwm_rate_strobe_or_serial_rx_o <= ~rate_conversion_active_i;
         pwm_rate_strobe_or_serial_rx_oe_o <= 1'b1;
         serial_rx_data_o <= 1'b1;
      end else begin
         // [R8] pin receives host uart data
         pwm_rate_strobe_or_serial_rx_o <= 1'b1;
         pwm_rate_strobe_or_serial_rx_oe_o <= 1'b0;
         serial_rx_data_o <= pwm_rate_strobe_or_serial_rx_i;
      end
   end

   // boost strobe on the strap pin after init, in standalone mode only
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mode_strap_boost_strobe_o <= 1'b1;
         mode_strap_boost_strobe_oe_o <= 1'b0;
      end else begin
         mode_strap_boost_strobe_o <= ~boost_conversion_active_i;
         mode_strap_boost_strobe_oe_o <= standalone && pwm_oe && !pin_reset;
      end
   end

   // status
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         standalone_mode_o <= 1'b0;
         pwm_active_low_o <= 1'b0;
         base_freq_60_o <= 1'b0;
         fault_active_o <= 1'b0;
         pwm_running_o <= 1'b0;
      end else begin
         standalone_mode_o <= standalone;
         pwm_active_low_o <= active_low;
         base_freq_60_o <= freq_60;
         fault_active_o <= state inside {mpc_pkg::ST_FAULT, mpc_pkg::ST_RETRY};
         pwm_running_o <= phase_bus.enable && !pin_reset;
      end
   end
endmodule
`default_nettype wire

// ### bench/mpc_top_asserts.sv
// concurrent checks on the pwm pin control ports
`timescale 1ns/100ps
`default_nettype none
module mpc_top_asserts (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic reset_pin_i,
   input wire logic reset_pin_o,
   input wire logic reset_pin_oe_o,
   input wire logic clock_loss_i,
   input wire logic low_supply_i,
   input wire logic system_fault_input_i,
   input wire logic rate_conversion_active_i,
   input wire logic pwm_rate_strobe_or_serial_rx_i,
   input wire logic pwm_rate_strobe_or_serial_rx_o,
   input wire logic pwm_rate_strobe_or_serial_rx_oe_o,
   input wire logic serial_rx_data_o,
   input wire logic standalone_mode_o,
   input wire logic pwm_active_low_o,
   input wire logic fault_active_o,
   input wire logic pwm_running_o,
   input wire logic phase_u_high_side_out_o,
   input wire logic phase_u_high_side_out_oe_o,
   input wire logic phase_u_low_side_out_o,
   input wire logic phase_u_low_side_out_oe_o,
   input wire logic phase_v_high_side_out_o,
   input wire logic phase_v_high_side_out_oe_o,
   input wire logic phase_v_low_side_out_o,
   input wire logic phase_v_low_side_out_oe_o,
   input wire logic phase_w_high_side_out_o,
   input wire logic phase_w_high_side_out_oe_o,
   input wire logic phase_w_low_side_out_o,
   input wire logic phase_w_low_side_out_oe_o
);
   logic [2:0] hi;
   logic [2:0] lo;
   logic [5:0] oev;
   logic [2:0] idle;
   assign hi = {phase_w_high_side_out_o, phase_v_high_side_out_o, phase_u_high_side_out_o};
   assign lo = {phase_w_low_side_out_o, phase_v_low_side_out_o, phase_u_low_side_out_o};
   assign idle = {3{pwm_active_low_o}};
   assign oev = {phase_w_high_side_out_oe_o, phase_w_low_side_out_oe_o, phase_v_high_side_out_oe_o,
      phase_v_low_side_out_oe_o, phase_u_high_side_out_oe_o, phase_u_low_side_out_oe_o};
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   chk_reset_drive: assert property (
      ##1 reset_pin_oe_o == $past(clock_loss_i | low_supply_i) && !reset_pin_o)
      else $error("reset pin drive wrong");
   chk_pin_hiz: assert property (!reset_pin_i |=> oev == 6'h00 && !pwm_running_o)
      else $error("pwm pins not released");
   chk_oe_match: assert property ((&oev) == (|oev))
      else $error("pwm enables differ");
   chk_no_shoot: assert property (oev[0] |-> ((hi ^ idle) & (lo ^ idle)) == 3'h0)
      else $error("both sides active");
   chk_fault_off: assert property (
      system_fault_input_i && reset_pin_i && oev[0] |=> !pwm_running_o && hi == idle && lo == idle)
      else $error("fault did not disable pwm");
   chk_fault_flag: assert property (
      pwm_running_o && system_fault_input_i && reset_pin_i |-> ##2 fault_active_o)
      else $error("fault flag late");
   chk_retry_hold: assert property (
      fault_active_o && system_fault_input_i && reset_pin_i |=>
      ##1 fault_active_o && !pwm_running_o)
      else $error("retry ran during fault");
   chk_rate_strobe: assert property (pwm_rate_strobe_or_serial_rx_oe_o |->
      standalone_mode_o && pwm_rate_strobe_or_serial_rx_o == !$past(rate_conversion_active_i))
      else $error("rate strobe wrong");
   chk_host_rx: assert property (!standalone_mode_o && pwm_running_o && $past(pwm_running_o) |->
      !pwm_rate_strobe_or_serial_rx_oe_o && serial_rx_data_o == $past(pwm_rate_strobe_or_serial_rx_i))
      else $error("serial rx path wrong");
endmodule
`default_nettype wire

// ### bench/mpc_power_stage.sv
// behavioural power stage: gate inputs and fault sensing
`timescale 1ns/100ps
`default_nettype none
module mpc_power_stage (
   input wire logic sys_clk_i,
   input wire logic trip_i,
   input wire logic oe_i,
   input wire logic act_low_i,
   input wire logic [2:0] hi_i,
   input wire logic [2:0] lo_i,
   output logic fault_o,
   output int shoots_o
);
   initial fault_o = 1'b0;
   initial shoots_o = 0;
   always @(posedge sys_clk_i) begin
      if (oe_i && (((hi_i ^ {3{act_low_i}}) & (lo_i ^ {3{act_low_i}})) != 3'h0)) begin
         shoots_o <= shoots_o + 1;
      end
      fault_o <= trip_i;
   end
endmodule
`default_nettype wire

// ### bench/motor_pwm_pin_control_bench.sv
// self-checking bench for the pwm pin control block
`timescale 1ns/100ps
`default_nettype none
module motor_pwm_pin_control_bench;
   localparam int TICK = 4;
   logic sys_clk_i = 1'b0, reset_n_i = 1'b0, ext_rst = 1'b1, strap = 1'b1, rx = 1'b1, trip = 1'b0;
   logic clock_loss_i = 1'b0, low_supply_i = 1'b0, polarity_base_freq_select_i = 1'b0;
   logic boost_conversion_active_i = 1'b0, rate_conversion_active_i = 1'b0;
   logic [2:0] phase_demand_i = 3'h0;
   logic [7:0] dead_time_code_i = 8'h00;
   logic [15:0] retry_time_code_i = 16'h0000;
   logic reset_pin_o, reset_pin_oe_o, mode_strap_boost_strobe_o, mode_strap_boost_strobe_oe_o;
   logic pwm_rate_strobe_or_serial_rx_o, pwm_rate_strobe_or_serial_rx_oe_o, serial_rx_data_o;
   logic phase_u_high_side_out_o, phase_u_high_side_out_oe_o, phase_u_low_side_out_o;
   logic phase_u_low_side_out_oe_o, phase_v_high_side_out_o, phase_v_high_side_out_oe_o;
   logic phase_v_low_side_out_o, phase_v_low_side_out_oe_o, phase_w_high_side_out_o;
   logic phase_w_high_side_out_oe_o, phase_w_low_side_out_o, phase_w_low_side_out_oe_o;
   logic standalone_mode_o, pwm_active_low_o, base_freq_60_o, fault_active_o, pwm_running_o;
   wire logic reset_pin_i, mode_strap_boost_strobe_i, pwm_rate_strobe_or_serial_rx_i;
   wire logic system_fault_input_i;
   int failures = 0, compares = 0, shoots;
   logic q[$];
   assign reset_pin_i = ext_rst & ~(reset_pin_oe_o & ~reset_pin_o);
   assign mode_strap_boost_strobe_i = mode_strap_boost_strobe_oe_o ? mode_strap_boost_strobe_o : strap;
   assign pwm_rate_strobe_or_serial_rx_i = pwm_rate_strobe_or_serial_rx_oe_o ?
      pwm_rate_strobe_or_serial_rx_o : rx;
   mpc_top #(.RETRY_TICK_CYCLES(TICK)) dut (.sys_clk_i, .reset_n_i, .reset_pin_i, .reset_pin_o,
      .reset_pin_oe_o, .clock_loss_i, .low_supply_i, .polarity_base_freq_select_i,
      .mode_strap_boost_strobe_i, .mode_strap_boost_strobe_o, .mode_strap_boost_strobe_oe_o,
      .boost_conversion_active_i, .system_fault_input_i, .pwm_rate_strobe_or_serial_rx_i,
      .pwm_rate_strobe_or_serial_rx_o, .pwm_rate_strobe_or_serial_rx_oe_o, .rate_conversion_active_i,
      .serial_rx_data_o, .phase_demand_i, .dead_time_code_i, .retry_time_code_i,
      .phase_u_high_side_out_o, .phase_u_high_side_out_oe_o, .phase_u_low_side_out_o,
      .phase_u_low_side_out_oe_o, .phase_v_high_side_out_o, .phase_v_high_side_out_oe_o,
      .phase_v_low_side_out_o, .phase_v_low_side_out_oe_o, .phase_w_high_side_out_o,
      .phase_w_high_side_out_oe_o, .phase_w_low_side_out_o, .phase_w_low_side_out_oe_o,
      .standalone_mode_o, .pwm_active_low_o, .base_freq_60_o, .fault_active_o, .pwm_running_o);
   mpc_power_stage stage (.sys_clk_i, .trip_i(trip), .oe_i(phase_u_high_side_out_oe_o),
      .act_low_i(pwm_active_low_o), .fault_o(system_fault_input_i), .shoots_o(shoots),
      .hi_i({phase_w_high_side_out_o, phase_v_high_side_out_o, phase_u_high_side_out_o}),
      .lo_i({phase_w_low_side_out_o, phase_v_low_side_out_o, phase_u_low_side_out_o}));
   always #2.5 sys_clk_i = ~sys_clk_i;
   function automatic int dt_exp(int code, logic sa);
      if (sa) code = code < 4 ? 4 : (code > 48 ? 48 : code);
      return code * mpc_pkg::DT_UNIT_CYC + 3;
   endfunction
   function automatic int rt_exp(int code, logic sa);
      if (sa && code > 212) code = 212;
      return code * TICK;
   endfunction
   task automatic tick(int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic init(logic sa, logic pol, logic frq);
      strap = sa;
      polarity_base_freq_select_i = pol;
      reset_n_i = 1'b0;
      tick(3);
      reset_n_i = 1'b1;
      tick(450);
      polarity_base_freq_select_i = frq;
      tick(200);
      check("mode", standalone_mode_o, sa);
      check("pol_freq", {pwm_active_low_o, base_freq_60_o}, {pol, frq});
      check("pwm_oe", phase_w_low_side_out_oe_o, 1'b1);
   endtask
   task automatic dt(logic [7:0] code, logic sa);
      int n;
      dead_time_code_i = code;
      tick(1300);
      phase_demand_i[0] = ~phase_demand_i[0];
      n = 0;
      while (n < 6000 && ((phase_demand_i[0] ? phase_u_high_side_out_o : phase_u_low_side_out_o)
            === pwm_active_low_o)) begin
         tick(1);
         n++;
      end
      check("dead_cycles", n, dt_exp(code, sa));
   endtask
   task automatic retry(logic [15:0] code, logic sa);
      int n, e;
      e = rt_exp(code, sa);
      retry_time_code_i = code;
      trip = 1'b1;
      tick(4 + $urandom_range(20));
      check("fault_state", {fault_active_o, pwm_running_o}, 2'b10);
      trip = 1'b0;
      n = 0;
      while (pwm_running_o !== 1'b1 && n < 5000) begin
         tick(1);
         n++;
      end
      check("retry_wait", n >= e && n <= e + 6, 1'b1);
      tick(1300);
   endtask
   initial begin
      void'($urandom(50692));
      init(1'b1, 1'b1, 1'b1);
      dt(8'h00, 1'b1);
      dt(8'hC8, 1'b1);
      dt(8'h0A, 1'b1);
      retry(16'h012C, 1'b1);
      retry(16'h0003, 1'b1);
      repeat (8) begin
         rate_conversion_active_i = 1'($urandom);
         boost_conversion_active_i = 1'($urandom);
         tick(1);
         check("rate_pin", {pwm_rate_strobe_or_serial_rx_oe_o, pwm_rate_strobe_or_serial_rx_o},
            {1'b1, ~rate_conversion_active_i});
         check("strap_pin", {mode_strap_boost_strobe_oe_o, mode_strap_boost_strobe_o},
            {1'b1, ~boost_conversion_active_i});
      end
      repeat (40) begin
         phase_demand_i = 3'($urandom);
         tick(1 + $urandom_range(60));
      end
      $display("test standalone done");
      init(1'b0, 1'b0, 1'b0);
      dt(8'h00, 1'b0);
      dt(8'hC8, 1'b0);
      retry(16'h012C, 1'b0);
      repeat (16) begin
         rx = 1'($urandom);
         q.push_back(rx);
         tick(1);
         check("serial_rx", {pwm_rate_strobe_or_serial_rx_oe_o, serial_rx_data_o},
            {1'b0, q.pop_front()});
      end
      $display("test host done");
      for (int i = 0; i < 2; i++) begin
         {low_supply_i, clock_loss_i} = i ? 2'b10 : 2'b01;
         tick(1);
         check("reset_drive", {reset_pin_oe_o, reset_pin_o}, 2'b10);
         {low_supply_i, clock_loss_i} = 2'b00;
         tick(2);
         check("restart", {phase_u_low_side_out_oe_o, pwm_running_o}, 2'b00);
         tick(700);
      end
      ext_rst = 1'b0;
      tick(2);
      check("pin_hiz", {phase_v_high_side_out_oe_o, pwm_running_o}, 2'b00);
      ext_rst = 1'b1;
      check("shoot_through", shoots, 0);
      $display("test reset done");
      finish_test();
   end
   initial begin
      #300000;
      failures++;
      finish_test();
   end
endmodule
bind mpc_top mpc_top_asserts chk (.sys_clk_i, .reset_n_i, .reset_pin_i, .reset_pin_o,
   .reset_pin_oe_o, .clock_loss_i, .low_supply_i, .system_fault_input_i, .rate_conversion_active_i,
   .pwm_rate_strobe_or_serial_rx_i, .pwm_rate_strobe_or_serial_rx_o,
   .pwm_rate_strobe_or_serial_rx_oe_o, .serial_rx_data_o, .standalone_mode_o, .pwm_active_low_o,
   .fault_active_o, .pwm_running_o, .phase_u_high_side_out_o, .phase_u_high_side_out_oe_o,
   .phase_u_low_side_out_o, .phase_u_low_side_out_oe_o, .phase_v_high_side_out_o,
   .phase_v_high_side_out_oe_o, .phase_v_low_side_out_o, .phase_v_low_side_out_oe_o,
   .phase_w_high_side_out_o, .phase_w_high_side_out_oe_o, .phase_w_low_side_out_o,
   .phase_w_low_side_out_oe_o);
`default_nettype wire
